// ---- logic/sccs_pkg.sv ----
package sccs_pkg;

    // flow and enable state of one serial channel
    typedef struct packed {
        logic rx_on;
        logic rx_stop;
        logic rx_resume;
        logic tx_on;
        logic tx_stop;
        logic tx_resume;
    } chan_flow_t;

    // preemptive special character request
    typedef struct packed {
        logic       chan;
        logic [1:0] index;
    } special_req_t;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_EXEC
    } cmd_state_t;

endpackage : sccs_pkg

// ---- logic/sccs_regs.svh ----
`ifndef SCCS_REGS_SVH
`define SCCS_REGS_SVH

// register offsets
`define SCCS_CMD_OFF      8'h05
`define SCCS_STAT_OFF     8'h0B
`define SCCS_CAR_OFF      8'h0C
`define SCCS_ISR_OFF      8'h0D
`define SCCS_IMR_OFF      8'h0E

// reset values
`define SCCS_CMD_RST      8'h00
`define SCCS_STAT_RST     8'h00
`define SCCS_CAR_RST      2'h0
`define SCCS_IRQ_RST      4'h0

// command register fields
`define SCCS_CMD_HI_MSB   7
`define SCCS_CMD_SC_BIT   5
`define SCCS_CMD_CTL_BIT  4
`define SCCS_CMD_TX_ON    3
`define SCCS_CMD_TX_OFF   2
`define SCCS_CMD_RX_ON    1
`define SCCS_CMD_RX_OFF   0
`define SCCS_SEL_MSB      2
`define SCCS_SEL_FIRST    3'h1
`define SCCS_SEL_LAST     3'h4
`define SCCS_SEL_XON      3'h1
`define SCCS_SEL_XOFF     3'h2

// status register fields
`define SCCS_ST_RXON      7
`define SCCS_ST_RXSTOP    6
`define SCCS_ST_RXRES     5
`define SCCS_ST_TXON      3
`define SCCS_ST_TXSTOP    2
`define SCCS_ST_TXRES     1

// channels that accept commands
`define SCCS_CHAN_A       2'h2
`define SCCS_CHAN_B       2'h3

// interrupt status bits
`define SCCS_IRQ_DONE     0
`define SCCS_IRQ_XOFF     1
`define SCCS_IRQ_XON      2
`define SCCS_IRQ_SENT     3

`endif

// ---- logic/serial_channel_command_status.sv ----
`timescale 1ns/10ps
`include "sccs_regs.svh"

// How it works
// RL1 - send-char format: bit5, selector bits 2:0
// RL2 - control format: bit4, tx/rx enable/disable bits
// RL3 - several control bits act together
// RL4 - all four combined control codes supported
// RL5 - control commands keep channel configuration
// RL6 - control command resumes remote-halted transmitter
// RL7 - read-only status at 0B, resets 00
// RL8 - status bit 7 shows receiver enabled
// RL9 - status bit 3 shows transmitter enabled
// RL10 - bit 6 set by XOFF send
// RL11 - bit 5 set by XON send
// RL12 - bit 2 set by received XOFF
// RL13 - bit 1 set by received XON
// RL14 - status bits 4 and 0 read zero
// RL15 - special char goes right after holding char
// RL16 - command register cleared after execution
// RL17 - only channels 2 and 3 accept commands
// RL18 - unused selector sends nothing, still clears
module serial_channel_command_status (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [7:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    output logic      [7:0] bus_rdata,
    output logic            irq,
    input  wire logic [1:0] rx_xoff_seen,
    input  wire logic [1:0] rx_xon_seen,
    input  wire logic [1:0] rx_data_seen,
    input  wire logic [1:0] tx_started,
    input  wire logic [1:0] chan_reset,
    output logic      [1:0] tx_enable,
    output logic      [1:0] rx_enable,
    output logic      [1:0] tx_halt,
    output logic            sc_req,
    output logic            sc_chan,
    output logic      [1:0] sc_index,
    input  wire logic       sc_ack
);

    logic [7:0]              cmd_ff;
    logic [1:0]              car_ff;
    logic [3:0]              isr_ff;
    logic [3:0]              nxt_isr;
    logic [3:0]              imr_ff;
    logic [7:0]              rdata_ff;
    logic                    irq_ff;
    logic                    sc_req_ff;
    sccs_pkg::special_req_t  sc_ff;
    sccs_pkg::cmd_state_t    state_ff;
    sccs_pkg::cmd_state_t    nxt_state;
    sccs_pkg::chan_flow_t    flow_ff [2];
    logic                    is_sc;
    logic                    is_ctl;
    logic                    sel_ok;
    logic                    chan_ok;
    logic                    stall;
    logic                    done;
    logic                    ctl_go;
    logic                    sc_go;
    logic [7:0]              status;
    logic [3:0]              events;
    logic                    wr_cmd;

    // command format decode
    always_comb
    begin
        is_sc   = (cmd_ff[`SCCS_CMD_HI_MSB:`SCCS_CMD_SC_BIT + 1] == 2'h0)
                  && cmd_ff[`SCCS_CMD_SC_BIT]
                  && (cmd_ff[`SCCS_CMD_CTL_BIT:`SCCS_CMD_TX_ON] == 2'h0); // RL1
        is_ctl  = (cmd_ff[`SCCS_CMD_HI_MSB:`SCCS_CMD_SC_BIT] == 3'h0)
                  && cmd_ff[`SCCS_CMD_CTL_BIT]; // RL2
        sel_ok  = (cmd_ff[`SCCS_SEL_MSB:0] >= `SCCS_SEL_FIRST)
                  && (cmd_ff[`SCCS_SEL_MSB:0] <= `SCCS_SEL_LAST); // RL18
        chan_ok = (car_ff == `SCCS_CHAN_A) || (car_ff == `SCCS_CHAN_B); // RL17
    end

    // a send waits while the previous special character is unsent
    assign stall  = (state_ff == sccs_pkg::ST_EXEC) && is_sc && sel_ok && chan_ok && sc_req_ff;
    assign done   = (state_ff == sccs_pkg::ST_EXEC) && !stall;
    assign ctl_go = done && is_ctl && chan_ok; // RL17
    assign sc_go  = done && is_sc && sel_ok && chan_ok; // RL18
    assign wr_cmd = bus_wr && (bus_addr == `SCCS_CMD_OFF);

    // command sequencer
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            sccs_pkg::ST_IDLE:
            begin
                if (cmd_ff != `SCCS_CMD_RST && !wr_cmd)
                begin
                    nxt_state = sccs_pkg::ST_EXEC;
                end
            end
            sccs_pkg::ST_EXEC:
            begin
                if (!stall)
                begin
                    nxt_state = sccs_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = sccs_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= sccs_pkg::ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // command register: host write, cleared once executed
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_ff <= `SCCS_CMD_RST;
        end
        else if (done)
        begin
            cmd_ff <= `SCCS_CMD_RST; // RL16
        end
        else if (wr_cmd)
        begin
            cmd_ff <= bus_wdata;
        end
    end

    // channel select register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            car_ff <= `SCCS_CAR_RST;
        end
        else if (bus_wr && bus_addr == `SCCS_CAR_OFF)
        begin
            car_ff <= bus_wdata[1:0];
        end
    end

    // per-channel enable and flow state; flow-bit clears come first so events win
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_chan
            logic sel_me;
            logic ctl_me;
            logic sc_me;
            logic rx_touch;

            assign sel_me   = (car_ff[0] == 1'(ch));
            assign ctl_me   = ctl_go && sel_me;
            assign sc_me    = sc_go && sel_me;
            assign rx_touch = ctl_me && (cmd_ff[`SCCS_CMD_RX_ON] || cmd_ff[`SCCS_CMD_RX_OFF]);

            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    flow_ff[ch] <= '0;
                end
                else if (chan_reset[ch])
                begin
                    flow_ff[ch] <= '0;
                end
                else
                begin
                    // each control bit acts on its own side; disable wins a clash
                    if (ctl_me && cmd_ff[`SCCS_CMD_TX_ON])
                    begin
                        flow_ff[ch].tx_on <= 1'b1; // RL3 RL4
                    end
                    if (ctl_me && cmd_ff[`SCCS_CMD_TX_OFF])
                    begin
                        flow_ff[ch].tx_on <= 1'b0; // RL3 RL4
                    end
                    if (ctl_me && cmd_ff[`SCCS_CMD_RX_ON])
                    begin
                        flow_ff[ch].rx_on <= 1'b1; // RL3 RL4
                    end
                    if (ctl_me && cmd_ff[`SCCS_CMD_RX_OFF])
                    begin
                        flow_ff[ch].rx_on <= 1'b0; // RL3 RL4
                    end
                    // receive-side flow bits follow the host's sends
                    if (ctl_me || (sc_me && cmd_ff[`SCCS_SEL_MSB:0] == `SCCS_SEL_XON))
                    begin
                        flow_ff[ch].rx_stop <= 1'b0; // RL10
                    end
                    if (sc_me && cmd_ff[`SCCS_SEL_MSB:0] == `SCCS_SEL_XOFF)
                    begin
                        flow_ff[ch].rx_stop <= 1'b1; // RL10
                    end
                    if (rx_touch || rx_data_seen[ch])
                    begin
                        flow_ff[ch].rx_resume <= 1'b0; // RL11
                    end
                    if (sc_me && cmd_ff[`SCCS_SEL_MSB:0] == `SCCS_SEL_XON)
                    begin
                        flow_ff[ch].rx_resume <= 1'b1; // RL11
                    end
                    // transmit-side flow bits follow the remote
                    if (ctl_me || rx_xon_seen[ch])
                    begin
                        flow_ff[ch].tx_stop <= 1'b0; // RL6 RL12
                    end
                    if (rx_xoff_seen[ch])
                    begin
                        flow_ff[ch].tx_stop <= 1'b1; // RL12
                    end
                    if (ctl_me || tx_started[ch])
                    begin
                        flow_ff[ch].tx_resume <= 1'b0; // RL13
                    end
                    if (rx_xon_seen[ch])
                    begin
                        flow_ff[ch].tx_resume <= 1'b1; // RL13
                    end
                end
            end

            // flow state drives the serial engine; no configuration is touched
            assign tx_enable[ch] = flow_ff[ch].tx_on; // RL5
            assign rx_enable[ch] = flow_ff[ch].rx_on;
            assign tx_halt[ch]   = flow_ff[ch].tx_stop; // RL6
        end
    endgenerate

    // preemptive special character request, held until the engine takes it
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sc_req_ff <= 1'b0;
            sc_ff     <= '0;
        end
        else if (sc_go)
        begin
            sc_req_ff   <= 1'b1; // RL15
            sc_ff.chan  <= car_ff[0];
            sc_ff.index <= 2'(cmd_ff[`SCCS_SEL_MSB:0] - `SCCS_SEL_FIRST);
        end
        else if (sc_ack)
        begin
            sc_req_ff <= 1'b0;
        end
    end

    assign sc_req   = sc_req_ff;
    assign sc_chan  = sc_ff.chan;
    assign sc_index = sc_ff.index;

    // status of the selected channel; zero when no serial channel selected
    always_comb
    begin
        status = `SCCS_STAT_RST; // RL14
        if (chan_ok)
        begin
            status[`SCCS_ST_RXON]   = flow_ff[car_ff[0]].rx_on; // RL8
            status[`SCCS_ST_RXSTOP] = flow_ff[car_ff[0]].rx_stop;
            status[`SCCS_ST_RXRES]  = flow_ff[car_ff[0]].rx_resume;
            status[`SCCS_ST_TXON]   = flow_ff[car_ff[0]].tx_on; // RL9
            status[`SCCS_ST_TXSTOP] = flow_ff[car_ff[0]].tx_stop;
            status[`SCCS_ST_TXRES]  = flow_ff[car_ff[0]].tx_resume;
        end
    end

    // interrupt events
    always_comb
    begin
        events                  = 4'h0;
        events[`SCCS_IRQ_DONE]  = done;
        events[`SCCS_IRQ_XOFF]  = |rx_xoff_seen;
        events[`SCCS_IRQ_XON]   = |rx_xon_seen;
        events[`SCCS_IRQ_SENT]  = sc_req_ff && sc_ack;
        nxt_isr                 = isr_ff;
        if (bus_wr && bus_addr == `SCCS_ISR_OFF)
        begin
            nxt_isr = nxt_isr & ~bus_wdata[3:0];
        end
        nxt_isr = nxt_isr | events;
    end

    // sticky status, mask and interrupt line
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            isr_ff <= `SCCS_IRQ_RST;
            imr_ff <= `SCCS_IRQ_RST;
            irq_ff <= 1'b0;
        end
        else
        begin
            isr_ff <= nxt_isr;
            irq_ff <= |(nxt_isr & imr_ff);
            if (bus_wr && bus_addr == `SCCS_IMR_OFF)
            begin
                imr_ff <= bus_wdata[3:0];
            end
        end
    end

    assign irq = irq_ff;

    // read port, data one cycle after the strobe; status is read-only
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_ff <= 8'h00;
        end
        else if (bus_rd)
        begin
            case (bus_addr)
                `SCCS_CMD_OFF:  rdata_ff <= cmd_ff;
                `SCCS_STAT_OFF: rdata_ff <= status; // RL7
                `SCCS_CAR_OFF:  rdata_ff <= {6'h00, car_ff};
                `SCCS_ISR_OFF:  rdata_ff <= {4'h0, isr_ff};
                `SCCS_IMR_OFF:  rdata_ff <= {4'h0, imr_ff};
                default:        rdata_ff <= 8'h00;
            endcase
        end
        else
        begin
            rdata_ff <= 8'h00;
        end
    end

    assign bus_rdata = rdata_ff;

endmodule : serial_channel_command_status

// ---- tb/remote_link_model.sv ----
`timescale 1ns/10ps

module remote_link_model #(
    parameter logic [7:0] XON_CHAR  = 8'h11,
    parameter logic [7:0] XOFF_CHAR = 8'h13
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [7:0] rx_char,
    input  wire logic       rx_valid,
    input  wire logic [3:0] ack_wait,
    input  wire logic       sc_req,
    input  wire logic       sc_chan,
    output logic      [1:0] rx_xoff_seen,
    output logic      [1:0] rx_xon_seen,
    output logic      [1:0] rx_data_seen,
    output logic      [1:0] tx_started,
    output logic            sc_ack
);
    logic [3:0] wait_ff;

    // sorts each character from the remote into a flow event of channel two
    assign rx_xoff_seen = {1'b0, rx_valid && rx_char == XOFF_CHAR};
    assign rx_xon_seen  = {1'b0, rx_valid && rx_char == XON_CHAR};
    assign rx_data_seen = {1'b0, rx_valid && rx_char != XON_CHAR && rx_char != XOFF_CHAR};
    assign tx_started   = sc_ack ? (sc_chan ? 2'b10 : 2'b01) : 2'b00;

    // takes a special request after the holding character, ack_wait cycles late
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wait_ff <= 4'h0;
            sc_ack  <= 1'b0;
        end
        else
        begin
            sc_ack  <= sc_req && !sc_ack && wait_ff == ack_wait;
            wait_ff <= (sc_req && !sc_ack && wait_ff != ack_wait) ? wait_ff + 4'h1 : 4'h0;
        end
    end
endmodule : remote_link_model

// ---- tb/sccs_asserts.sv ----
`timescale 1ns/10ps

module sccs_checker (
    input wire logic       mclk,
    input wire logic       arst_n,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic [1:0] rx_xoff_seen,
    input wire logic [1:0] rx_xon_seen,
    input wire logic [1:0] chan_reset,
    input wire logic [1:0] tx_enable,
    input wire logic [1:0] rx_enable,
    input wire logic [1:0] tx_halt,
    input wire logic       sc_req,
    input wire logic       sc_chan,
    input wire logic [1:0] sc_index,
    input wire logic       sc_ack
);
    logic [1:0] sel_ff;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // follows the channel select register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            sel_ff <= 2'h0;
        else if (bus_wr && bus_addr == 8'h0C)
            sel_ff <= bus_wdata[1:0];
    end

    // command write while channel two is selected
    sequence cmd_wr(logic [7:0] m);
        bus_wr && bus_addr == 8'h05 && bus_wdata == m && sel_ff == 2'h2;
    endsequence

    // status read of a channel that takes commands
    sequence st_rd;
        $past(bus_rd) && $past(bus_addr) == 8'h0B && sel_ff[1];
    endsequence

    rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not idle");
    status_map_a: assert property (st_rd |-> bus_rdata[3] == $past(tx_enable[sel_ff[0]])
        && bus_rdata[7] == $past(rx_enable[sel_ff[0]]) && bus_rdata[2] == $past(tx_halt[sel_ff[0]])
        && bus_rdata[4] == 1'b0 && bus_rdata[0] == 1'b0) else $error("status bits wrong");
    halt_set_a: assert property (rx_xoff_seen[0] && !chan_reset[0] |=> tx_halt[0])
        else $error("halt not set");
    halt_clear_a: assert property (rx_xon_seen[0] && !rx_xoff_seen[0] |=> !tx_halt[0])
        else $error("halt not cleared");
    en_both_a: assert property (cmd_wr(8'h1A) |-> ##3 tx_enable[0] && rx_enable[0] && !tx_halt[0])
        else $error("enable both failed");
    dis_both_a: assert property (cmd_wr(8'h15) |-> ##3 !tx_enable[0] && !rx_enable[0])
        else $error("disable both failed");
    sc_issue_a: assert property (cmd_wr(8'h22) |-> ##3 sc_req && sc_index == 2'h1 && !sc_chan)
        else $error("special request wrong");
    unused_sel_a: assert property (cmd_wr(8'h25) |=> !sc_req [*4])
        else $error("unused selector sent");
    sc_hold_a: assert property (sc_req && !sc_ack |=> sc_req && $stable(sc_index) && $stable(sc_chan))
        else $error("request dropped early");
    sc_release_a: assert property (sc_req && sc_ack |=> !sc_req)
        else $error("request not released");
    ignore_chan_a: assert property (bus_wr && bus_addr == 8'h05 && !sel_ff[1]
        |-> ##3 tx_enable == $past(tx_enable, 3) && rx_enable == $past(rx_enable, 3))
        else $error("ignored channel acted");
endmodule : sccs_checker

// ---- tb/test_serial_channel_command_status.sv ----
`timescale 1ns/10ps

module test_serial_channel_command_status;
    localparam logic [7:0] XON  = 8'h11;
    localparam logic [7:0] XOFF = 8'h13;
    logic       mclk, arst_n, bus_wr, bus_rd, irq, sc_req, sc_chan, sc_ack, rx_valid;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, rx_char, rv;
    logic [3:0] ack_wait;
    logic [1:0] rx_xoff_seen, rx_xon_seen, rx_data_seen, tx_started, chan_reset;
    logic [1:0] tx_enable, rx_enable, tx_halt, sc_index;
    int         miscompares = 0;
    int         n_checks = 0;
    logic [7:0] ctl_cmd [8] = '{8'h15, 8'h1A, 8'h16, 8'h19, 8'h12, 8'h14, 8'h11, 8'h18};
    logic [7:0] ctl_st  [8] = '{8'h00, 8'h88, 8'h80, 8'h08, 8'h88, 8'h80, 8'h00, 8'h08};
    logic [7:0] bad_sel [4] = '{8'h20, 8'h25, 8'h26, 8'h27};

    serial_channel_command_status u_dut (.mclk(mclk), .arst_n(arst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
        .rx_xoff_seen(rx_xoff_seen), .rx_xon_seen(rx_xon_seen), .rx_data_seen(rx_data_seen),
        .tx_started(tx_started), .chan_reset(chan_reset), .tx_enable(tx_enable), .rx_enable(rx_enable),
        .tx_halt(tx_halt), .sc_req(sc_req), .sc_chan(sc_chan), .sc_index(sc_index), .sc_ack(sc_ack));

    remote_link_model #(.XON_CHAR(XON), .XOFF_CHAR(XOFF)) u_remote (.mclk(mclk), .arst_n(arst_n),
        .rx_char(rx_char), .rx_valid(rx_valid), .ack_wait(ack_wait), .sc_req(sc_req), .sc_chan(sc_chan),
        .rx_xoff_seen(rx_xoff_seen), .rx_xon_seen(rx_xon_seen), .rx_data_seen(rx_data_seen),
        .tx_started(tx_started), .sc_ack(sc_ack));

    // free running clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            miscompares++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 rv = bus_rdata;
    endtask : rd

    // writes a command and waits for the register to clear
    task automatic cmd(input logic [7:0] d);
        wr(8'h05, d);
        rv = 8'hFF;
        for (int i = 0; i < 30 && rv !== 8'h00; i++)
            rd(8'h05);
        chk("command", rv, 8'h00);
    endtask : cmd

    task automatic st(input logic [7:0] e);
        rd(8'h0B);
        chk("status", rv, e);
    endtask : st

    task automatic rxc(input logic [7:0] c);
        @(posedge mclk);
        rx_char <= c;
        rx_valid <= 1'b1;
        @(posedge mclk);
        rx_valid <= 1'b0;
    endtask : rxc

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // cuts a hang short
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        conclude();
    end

    // main sequence
    initial
    begin
        {arst_n, bus_wr, bus_rd, rx_valid, bus_addr, bus_wdata, rx_char, chan_reset} = '0;
        ack_wait = 4'h6;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        st(8'h00);
        wr(8'h0C, 8'h02);
        wr(8'h0B, 8'hFF);
        st(8'h00);
        rd(8'h40);
        chk("unmapped", rv, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            cmd(ctl_cmd[i]);
            st(ctl_st[i]);
        end
        cmd(8'h12);
        cmd(8'h22);
        st(8'hC8);
        ack_wait <= 4'h0;
        cmd(8'h21);
        st(8'hA8);
        rxc(8'h41);
        st(8'h88);
        cmd(8'h21);
        cmd(8'h18);
        st(8'hA8);
        cmd(8'h12);
        st(8'h88);
        cmd(8'h22);
        cmd(8'h18);
        st(8'h88);
        rxc(XOFF);
        st(8'h8C);
        rxc(XON);
        st(8'h8A);
        cmd(8'h23);
        st(8'h88);
        rxc(XOFF);
        cmd(8'h1A);
        st(8'h88);
        chk("halt", {6'h00, tx_halt}, 8'h00);
        cmd(8'h22);
        for (int i = 0; i < 4; i++)
        begin
            cmd(bad_sel[i]);
            st(8'hC8);
        end
        cmd(8'h1A);
        wr(8'h0C, 8'h01);
        cmd(8'h15);
        st(8'h00);
        wr(8'h0C, 8'h02);
        st(8'h88);
        wr(8'h0C, 8'h03);
        cmd(8'h1A);
        st(8'h88);
        chk("tx enable", {6'h00, tx_enable}, 8'h03);
        rd(8'h0C);
        chk("select", rv, 8'h03);
        cmd(8'h24);
        chk("special", {5'h00, sc_chan, sc_index}, 8'h07);
        wr(8'h0D, 8'h0F);
        wr(8'h0E, 8'h01);
        cmd(8'h18);
        chk("irq", {7'h00, irq}, 8'h01);
        wr(8'h0D, 8'h01);
        repeat (2) @(posedge mclk);
        #1 chk("irq", {7'h00, irq}, 8'h00);
        wr(8'h0E, 8'h00);
        cmd(8'h18);
        rd(8'h0D);
        chk("isr", rv, 8'h01);
        chk("irq", {7'h00, irq}, 8'h00);
        @(posedge mclk);
        chan_reset <= 2'b10;
        @(posedge mclk);
        chan_reset <= 2'b00;
        st(8'h00);
        conclude();
    end
endmodule : test_serial_channel_command_status

bind serial_channel_command_status sccs_checker u_chk (.mclk, .arst_n, .bus_addr, .bus_wdata, .bus_wr,
    .bus_rd, .bus_rdata, .rx_xoff_seen, .rx_xon_seen, .chan_reset, .tx_enable, .rx_enable, .tx_halt,
    .sc_req, .sc_chan, .sc_index, .sc_ack);
